// ===== system_configuration_reg.sv
// system configuration register with fixed-range and top-of-memory steering
//
// Contract
// RL1: register sits at one model register address
// RL2: access only via privileged model register instructions
// RL3: bits 21..18 read/write, others reserved
// RL4: fixed dram enable makes range attributes effective
// RL5: honoured attributes steer fixed ranges as I/O
// RL6: modify enable lets attribute bits read, write
// RL7: modify disabled: writes ignored, reads zero
// RL8: variable enable activates top-of-memory and ranges
// RL9: variable enable clear disables them entirely
// RL10: high top-of-memory works only with its enable
// RL11: enabled top-of-memory marks ranges memory-mapped I/O
// RL12: fixed ranges lie within the lowest megabyte
// RL13: reserved bits read zero, ignore writes
`timescale 1ns/1ps
module system_configuration_reg #(
  parameter int PA_W = 40
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // model register access port
  input wire logic [31:0] msr_addr_in,
  input wire logic msr_rd_in,
  input wire logic msr_wr_in,
  input wire logic msr_priv_in,
  input wire logic [31:0] msr_wdata_in,
  output logic [31:0] msr_rdata_out,
  output logic msr_ack_out,
  output logic msr_fault_out,
  // fixed-range attribute access port
  input wire logic [sys_cfg_pkg::FIX_IDX_W-1:0] attr_sel_in,
  input wire logic attr_rd_in,
  input wire logic attr_wr_in,
  input wire logic [1:0] attr_wdata_in,
  output logic [1:0] attr_rdata_out,
  // physical address classification
  input wire logic phys_valid_in,
  input wire logic [PA_W-1:0] phys_addr_in,
  input wire logic [PA_W-1:0] top_mem_in,
  input wire logic [PA_W-1:0] top_mem_high_in,
  input wire logic var_io_hit_in,
  output logic class_valid_out,
  output logic mmio_out,
  output logic read_to_dram_out,
  output logic write_to_dram_out,
  // enable bits as seen by the memory-typing logic
  output logic top_mem_high_enable_out,
  output logic var_dram_enable_out,
  output logic fixed_attr_modify_enable_out,
  output logic fixed_dram_attr_enable_out
);
  localparam int IDX_W = sys_cfg_pkg::FIX_IDX_W;
  localparam int EN_W = sys_cfg_pkg::TOP_MEM_HIGH_ENABLE_EN_POS - sys_cfg_pkg::FIX_DRAM_EN_POS + 1;
  localparam int TOP_MEM_HIGH_ENABLE_I = sys_cfg_pkg::TOP_MEM_HIGH_ENABLE_EN_POS - sys_cfg_pkg::FIX_DRAM_EN_POS;
  localparam int VAR_I = sys_cfg_pkg::VAR_DRAM_EN_POS - sys_cfg_pkg::FIX_DRAM_EN_POS;
  localparam int MOD_I = sys_cfg_pkg::FIX_MOD_EN_POS - sys_cfg_pkg::FIX_DRAM_EN_POS;
  localparam int FIX_I = 0;
  localparam logic [PA_W-1:0] HIGH_BASE = PA_W'(1) << sys_cfg_pkg::HIGH_MEM_BIT;

  // ****************************************
  // elaboration checks
  // ****************************************
  if (PA_W < sys_cfg_pkg::HIGH_MEM_BIT + 1 || PA_W > 64) begin : g_pa_check
    $error("physical address width must be 33 to 64");
  end
  if ((1 << IDX_W) < sys_cfg_pkg::FIX_RANGES) begin : g_idx_check
    $error("fixed-range index too narrow");
  end

  // ****************************************
  // state
  // ****************************************
  logic [EN_W-1:0] cfg_bits;
  logic [EN_W-1:0] next_cfg_bits;
  logic [31:0] next_rdata;
  logic next_ack;
  logic next_fault;
  logic [1:0] next_attr_rdata;
  logic next_class_valid;
  logic next_mmio;
  logic next_rd_dram;
  logic next_wr_dram;
  logic req;
  logic hit;
  logic [31:0] cfg_word;
  logic low_mem;
  logic above_top;
  logic in_high_window;

  attr_if #(.IDX_W(IDX_W)) attr_bus ();

  // ****************************************
  // fixed-range index of a low address
  // ****************************************
  function automatic logic [IDX_W-1:0] fix_index(input logic [19:0] a);
    logic [IDX_W-1:0] r;
    if (!a[19]) begin
      r = IDX_W'(a[18:16]); // 64K ranges
    end else if (!a[18]) begin
      r = IDX_W'(sys_cfg_pkg::FIX_64K_CNT) + IDX_W'(a[17:14]); // 16K ranges
    end else begin
      r = IDX_W'(sys_cfg_pkg::FIX_64K_CNT + sys_cfg_pkg::FIX_16K_CNT) + IDX_W'(a[17:12]);
    end
    return r;
  endfunction : fix_index

  // ****************************************
  // register word with reserved bits at zero
  // ****************************************
  always_comb begin
    cfg_word = 32'h0; // RL13
    cfg_word[sys_cfg_pkg::TOP_MEM_HIGH_ENABLE_EN_POS:sys_cfg_pkg::FIX_DRAM_EN_POS] = cfg_bits; // RL3
  end

  // ****************************************
  // model register access
  // ****************************************
  always_comb begin
    req = msr_rd_in || msr_wr_in;
    hit = (msr_addr_in == sys_cfg_pkg::SYS_CFG_ADDR); // RL1
    next_cfg_bits = cfg_bits;
    next_rdata = 32'h0;
    next_ack = req;
    next_fault = req && !(hit && msr_priv_in); // RL2
    if (req && hit && msr_priv_in) begin
      if (msr_rd_in) begin
        next_rdata = cfg_word;
      end
      if (msr_wr_in) begin
        next_cfg_bits = msr_wdata_in[sys_cfg_pkg::TOP_MEM_HIGH_ENABLE_EN_POS:sys_cfg_pkg::FIX_DRAM_EN_POS]; // RL3
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      cfg_bits <= sys_cfg_pkg::CFG_RESET;
      msr_rdata_out <= 32'h0;
      msr_ack_out <= 1'b0;
      msr_fault_out <= 1'b0;
    end else begin
      cfg_bits <= next_cfg_bits;
      msr_rdata_out <= next_rdata;
      msr_ack_out <= next_ack;
      msr_fault_out <= next_fault;
    end
  end

  // enables leave straight from the register bits
  assign top_mem_high_enable_out = cfg_bits[TOP_MEM_HIGH_ENABLE_I];
  assign var_dram_enable_out = cfg_bits[VAR_I];
  assign fixed_attr_modify_enable_out = cfg_bits[MOD_I];
  assign fixed_dram_attr_enable_out = cfg_bits[FIX_I];

  // ****************************************
  // fixed-range attribute store
  // ****************************************
  assign attr_bus.sel = attr_sel_in;
  assign attr_bus.wr = attr_wr_in;
  assign attr_bus.wdata = attr_wdata_in;
  assign attr_bus.modify_en = cfg_bits[MOD_I]; // RL6 RL7
  assign attr_bus.look_idx = fix_index(phys_addr_in[sys_cfg_pkg::LOW_MEM_BITS-1:0]); // RL12

  fixed_attr_store #(
    .RANGES(sys_cfg_pkg::FIX_RANGES)
  ) u_attr (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .port_if(attr_bus)
  );

  // ****************************************
  // address classification
  // ****************************************
  always_comb begin
    next_attr_rdata = attr_rd_in ? attr_bus.rdata : 2'h0; // RL7
    low_mem = (phys_addr_in[PA_W-1:sys_cfg_pkg::LOW_MEM_BITS] == '0); // RL12
    above_top = cfg_bits[VAR_I] && (phys_addr_in >= top_mem_in); // RL8 RL9
    in_high_window = cfg_bits[TOP_MEM_HIGH_ENABLE_I] && (phys_addr_in >= HIGH_BASE) &&
      (phys_addr_in < top_mem_high_in); // RL10
    next_class_valid = phys_valid_in;
    next_mmio = 1'b0;
    next_rd_dram = 1'b1;
    next_wr_dram = 1'b1;
    if (low_mem) begin
      if (cfg_bits[FIX_I]) begin // RL4
        next_rd_dram = attr_bus.look_attr[sys_cfg_pkg::ATTR_RD_POS]; // RL5
        next_wr_dram = attr_bus.look_attr[sys_cfg_pkg::ATTR_WR_POS]; // RL5
      end
    end else begin
      next_mmio = (above_top && !in_high_window) || (cfg_bits[VAR_I] && var_io_hit_in); // RL11
      next_rd_dram = !next_mmio;
      next_wr_dram = !next_mmio;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      attr_rdata_out <= 2'h0;
      class_valid_out <= 1'b0;
      mmio_out <= 1'b0;
      read_to_dram_out <= 1'b1;
      write_to_dram_out <= 1'b1;
    end else begin
      attr_rdata_out <= next_attr_rdata;
      class_valid_out <= next_class_valid;
      mmio_out <= next_mmio;
      read_to_dram_out <= next_rd_dram;
      write_to_dram_out <= next_wr_dram;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);

  req_ack_time_a: assert property ((msr_rd_in || msr_wr_in) |=> msr_ack_out) // RL2
    else $error("access not answered in one cycle");
  unpriv_fault_a: assert property ((msr_rd_in || msr_wr_in) && !msr_priv_in // RL2
    |=> msr_fault_out && msr_rdata_out == 32'h0)
    else $error("unprivileged access not faulted");
  addr_write_a: assert property (msr_wr_in && msr_priv_in && hit // RL1
    |=> cfg_bits == $past(msr_wdata_in[21:18]))
    else $error("enable bits not written");
  miss_stable_a: assert property (!(msr_wr_in && msr_priv_in && hit) // RL1
    |=> $stable(cfg_bits))
    else $error("enable bits changed without a write");
  reserved_read_a: assert property (msr_ack_out |-> // RL13
    msr_rdata_out[31:22] == 10'h0 && msr_rdata_out[17:0] == 18'h0)
    else $error("reserved bits read nonzero");
  readback_a: assert property (msr_rd_in && !msr_wr_in && msr_priv_in && hit // RL3
    |=> msr_rdata_out[21:18] == $past(cfg_bits))
    else $error("enable bits read back wrong");
  attr_zero_a: assert property (attr_rd_in && !cfg_bits[MOD_I] // RL7
    |=> attr_rdata_out == 2'h0)
    else $error("attribute read not zero while modify disabled");
  fix_off_a: assert property (phys_valid_in && low_mem && !cfg_bits[FIX_I] // RL4
    |=> class_valid_out && read_to_dram_out && write_to_dram_out && !mmio_out)
    else $error("fixed attributes used while disabled");
  var_off_a: assert property (phys_valid_in && !low_mem && !cfg_bits[VAR_I] // RL9
    |=> !mmio_out && read_to_dram_out)
    else $error("top of memory acted while disabled");
  high_window_a: assert property (phys_valid_in && above_top && !low_mem && // RL10
    !var_io_hit_in && phys_addr_in >= HIGH_BASE && phys_addr_in < top_mem_high_in
    |=> mmio_out == !$past(cfg_bits[TOP_MEM_HIGH_ENABLE_I]))
    else $error("high top of memory enable misapplied");

  fault_seen_c: cover property (msr_wr_in && !hit ##1 msr_fault_out);
  write_read_c: cover property (msr_wr_in && msr_priv_in && hit ##1
    msr_rd_in && msr_priv_in && hit);
  fixed_io_c: cover property (class_valid_out && !read_to_dram_out && !mmio_out);
  high_dram_c: cover property (phys_valid_in && above_top && in_high_window);
endmodule : system_configuration_reg

// ===== sys_cfg_pkg.sv
// constants shared by the system configuration register and its attribute store
package sys_cfg_pkg;
  // ****************************************
  // register address and field positions
  // ****************************************
  localparam logic [31:0] SYS_CFG_ADDR = 32'hC001_0010;
  localparam int TOP_MEM_HIGH_ENABLE_EN_POS = 21;
  localparam int VAR_DRAM_EN_POS = 20;
  localparam int FIX_MOD_EN_POS = 19;
  localparam int FIX_DRAM_EN_POS = 18;
  localparam int RSVD_HI_LSB = 22;
  localparam int RSVD_LO_MSB = 17;
  localparam logic [3:0] CFG_RESET = 4'h0;

  // ****************************************
  // fixed-range layout below one megabyte
  // ****************************************
  localparam int LOW_MEM_BITS = 20;
  localparam int FIX_64K_CNT = 8;
  localparam int FIX_16K_CNT = 16;
  localparam int FIX_4K_CNT = 64;
  localparam int FIX_RANGES = FIX_64K_CNT + FIX_16K_CNT + FIX_4K_CNT;
  localparam int FIX_IDX_W = 7;
  localparam int ATTR_RD_POS = 1;
  localparam int ATTR_WR_POS = 0;
  localparam logic [1:0] ATTR_RESET = 2'h0;
  localparam int HIGH_MEM_BIT = 32;
endpackage : sys_cfg_pkg

// ===== attr_if.sv
// carrier between the configuration register and the fixed-range attribute store
`timescale 1ns/1ps
interface attr_if #(
  parameter int IDX_W = 7
);
  logic [IDX_W-1:0] sel;
  logic wr;
  logic [1:0] wdata;
  logic [1:0] rdata;
  logic modify_en;
  logic [IDX_W-1:0] look_idx;
  logic [1:0] look_attr;

  modport ctrl (output sel, output wr, output wdata, output modify_en, output look_idx,
    input rdata, input look_attr);
  modport store (input sel, input wr, input wdata, input modify_en, input look_idx,
    output rdata, output look_attr);
endinterface : attr_if

// ===== fixed_attr_store.sv
// read-to-dram and write-to-dram attribute bits of the fixed ranges
`timescale 1ns/1ps
module fixed_attr_store #(
  parameter int RANGES = 88
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // attribute access and lookup
  attr_if.store port_if
);
  logic [1:0] attr [RANGES];
  logic [1:0] next_attr [RANGES];

  // an empty store cannot serve any lookup
  if (RANGES < 1) begin : g_ranges_check
    $error("attribute store needs at least one range");
  end

  // ****************************************
  // update, gated by the modify enable
  // ****************************************
  always_comb begin
    next_attr = attr;
    if (port_if.wr && port_if.modify_en && (int'(port_if.sel) < RANGES)) begin // RL6 RL7
      next_attr[port_if.sel] = port_if.wdata;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < RANGES; i++) begin
        attr[i] <= sys_cfg_pkg::ATTR_RESET;
      end
    end else begin
      attr <= next_attr;
    end
  end

  // reads return zero while modification is off
  assign port_if.rdata = (port_if.modify_en && (int'(port_if.sel) < RANGES)) ?
    attr[port_if.sel] : 2'h0; // RL7
  assign port_if.look_attr = attr[port_if.look_idx];

  // ****************************************
  // checks
  // ****************************************
  attr_write_ok_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RL6
    port_if.wr && port_if.modify_en && (int'(port_if.sel) < RANGES)
    |=> attr[$past(port_if.sel)] == $past(port_if.wdata))
    else $error("attribute write lost while modify enabled");
  attr_write_block_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RL7
    port_if.wr && !port_if.modify_en && (int'(port_if.sel) < RANGES)
    |=> attr[$past(port_if.sel)] == $past(attr[port_if.sel]))
    else $error("attribute changed while modify disabled");
endmodule : fixed_attr_store

// ===== system_configuration_reg_bench.sv
// self-checking bench for the system configuration register
`timescale 1ns/1ps
module system_configuration_reg_bench;
  // ****************************************
  // stimulus and observation signals
  // ****************************************
  localparam int PA_W = 40;
  localparam logic [31:0] ADDR = sys_cfg_pkg::SYS_CFG_ADDR;
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [31:0] msr_addr_in = 32'h0;
  logic msr_rd_in = 1'b0;
  logic msr_wr_in = 1'b0;
  logic msr_priv_in = 1'b0;
  logic [31:0] msr_wdata_in = 32'h0;
  logic [31:0] msr_rdata_out;
  logic msr_ack_out;
  logic msr_fault_out;
  logic [sys_cfg_pkg::FIX_IDX_W-1:0] attr_sel_in = 7'h0;
  logic attr_rd_in = 1'b0;
  logic attr_wr_in = 1'b0;
  logic [1:0] attr_wdata_in = 2'h0;
  logic [1:0] attr_rdata_out;
  logic phys_valid_in = 1'b0;
  logic [PA_W-1:0] phys_addr_in = 40'h0;
  logic [PA_W-1:0] top_mem_in = 40'h00_4000_0000;
  logic [PA_W-1:0] top_mem_high_in = 40'h02_0000_0000;
  logic var_io_hit_in = 1'b0;
  logic class_valid_out, mmio_out, read_to_dram_out, write_to_dram_out;
  logic top_mem_high_enable_out, var_dram_enable_out;
  logic fixed_attr_modify_enable_out, fixed_dram_attr_enable_out;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  // device under test
  system_configuration_reg #(.PA_W(PA_W)) uut (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .msr_addr_in(msr_addr_in),
    .msr_rd_in(msr_rd_in), .msr_wr_in(msr_wr_in), .msr_priv_in(msr_priv_in),
    .msr_wdata_in(msr_wdata_in), .msr_rdata_out(msr_rdata_out), .msr_ack_out(msr_ack_out),
    .msr_fault_out(msr_fault_out), .attr_sel_in(attr_sel_in), .attr_rd_in(attr_rd_in),
    .attr_wr_in(attr_wr_in), .attr_wdata_in(attr_wdata_in), .attr_rdata_out(attr_rdata_out),
    .phys_valid_in(phys_valid_in), .phys_addr_in(phys_addr_in), .top_mem_in(top_mem_in),
    .top_mem_high_in(top_mem_high_in), .var_io_hit_in(var_io_hit_in),
    .class_valid_out(class_valid_out), .mmio_out(mmio_out),
    .read_to_dram_out(read_to_dram_out), .write_to_dram_out(write_to_dram_out),
    .top_mem_high_enable_out(top_mem_high_enable_out),
    .var_dram_enable_out(var_dram_enable_out),
    .fixed_attr_modify_enable_out(fixed_attr_modify_enable_out),
    .fixed_dram_attr_enable_out(fixed_dram_attr_enable_out));

  // ****************************************
  // clock, timeout and shared tasks
  // ****************************************
  initial begin
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  // cut a hang short well past the expected run length
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors = n_errors + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // one model register access, answer judged one edge after the strobe
  task automatic model_specific_reg(input logic wr, input logic rd, input logic [31:0] addr,
    input logic priv, input logic [31:0] wd, input logic [31:0] exp_rd, input logic exp_flt);
    @(posedge ref_clk_in);
    msr_wr_in <= wr;
    msr_rd_in <= rd;
    msr_addr_in <= addr;
    msr_priv_in <= priv;
    msr_wdata_in <= wd;
    @(posedge ref_clk_in);
    msr_wr_in <= 1'b0;
    msr_rd_in <= 1'b0;
    #1;
    check(msr_ack_out, 1'b1);
    check(msr_fault_out, exp_flt);
    check(msr_rdata_out, exp_rd);
  endtask : model_specific_reg

  // one attribute access, read data judged one edge later
  task automatic attr(input logic wr, input logic [6:0] sel, input logic [1:0] wd,
    input logic [1:0] exp);
    @(posedge ref_clk_in);
    attr_wr_in <= wr;
    attr_rd_in <= ~wr;
    attr_sel_in <= sel;
    attr_wdata_in <= wd;
    @(posedge ref_clk_in);
    attr_wr_in <= 1'b0;
    attr_rd_in <= 1'b0;
    #1;
    check(attr_rdata_out, wr ? 2'h0 : exp);
  endtask : attr

  // one classification request, result is {mmio, read, write}
  task automatic cls(input logic [PA_W-1:0] a, input logic hit, input logic [2:0] exp);
    @(posedge ref_clk_in);
    phys_valid_in <= 1'b1;
    phys_addr_in <= a;
    var_io_hit_in <= hit;
    @(posedge ref_clk_in);
    phys_valid_in <= 1'b0;
    #1;
    check(class_valid_out, 1'b1);
    check({mmio_out, read_to_dram_out, write_to_dram_out}, exp);
  endtask : cls

  task automatic set_cfg(input logic [3:0] en);
    model_specific_reg(1'b1, 1'b0, ADDR, 1'b1, {10'h0, en, 18'h0}, 32'h0, 1'b0);
    check({top_mem_high_enable_out, var_dram_enable_out, fixed_attr_modify_enable_out,
      fixed_dram_attr_enable_out}, en);
  endtask : set_cfg

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_register();
    model_specific_reg(1'b0, 1'b1, ADDR, 1'b1, 32'h0, 32'h0, 1'b0);
    model_specific_reg(1'b1, 1'b0, ADDR, 1'b1, 32'hFFFF_FFFF, 32'h0, 1'b0);
    model_specific_reg(1'b0, 1'b1, ADDR, 1'b1, 32'h0, 32'h003C_0000, 1'b0);
    model_specific_reg(1'b1, 1'b1, ADDR, 1'b1, 32'h0004_0000, 32'h003C_0000, 1'b0);
    model_specific_reg(1'b1, 1'b0, 32'hC001_0011, 1'b1, 32'h0, 32'h0, 1'b1);
    model_specific_reg(1'b1, 1'b0, ADDR, 1'b0, 32'h0, 32'h0, 1'b1);
    model_specific_reg(1'b0, 1'b1, ADDR, 1'b1, 32'h0, 32'h0004_0000, 1'b0);
    set_cfg(4'h0);
    $display("register test done");
  endtask : t_register

  task automatic t_attributes();
    attr(1'b1, 7'h03, 2'h2, 2'h0);
    set_cfg(4'h2);
    attr(1'b0, 7'h03, 2'h0, 2'h0);
    attr(1'b1, 7'h03, 2'h2, 2'h0);
    attr(1'b0, 7'h03, 2'h0, 2'h2);
    attr(1'b1, 7'h57, 2'h3, 2'h0);
    attr(1'b0, 7'h57, 2'h0, 2'h3);
    set_cfg(4'h0);
    attr(1'b0, 7'h03, 2'h0, 2'h0);
    attr(1'b1, 7'h03, 2'h1, 2'h0);
    set_cfg(4'h2);
    attr(1'b0, 7'h03, 2'h0, 2'h2);
    $display("attribute test done");
  endtask : t_attributes

  task automatic t_classify();
    set_cfg(4'h0);
    cls(40'h00_0003_0000, 1'b0, 3'b011);
    cls(40'h00_5000_0000, 1'b1, 3'b011);
    set_cfg(4'h1);
    cls(40'h00_0003_0000, 1'b0, 3'b010);
    cls(40'h00_000F_F000, 1'b0, 3'b011);
    cls(40'h00_000C_0000, 1'b0, 3'b000);
    cls(40'h00_5000_0000, 1'b0, 3'b011);
    set_cfg(4'h4);
    cls(40'h00_5000_0000, 1'b0, 3'b100);
    cls(40'h00_1000_0000, 1'b0, 3'b011);
    cls(40'h00_1000_0000, 1'b1, 3'b100);
    cls(40'h01_0000_0000, 1'b0, 3'b100);
    set_cfg(4'hC);
    cls(40'h01_0000_0000, 1'b0, 3'b011);
    cls(40'h03_0000_0000, 1'b0, 3'b100);
    $display("classification test done");
  endtask : t_classify

  // reset in mid-run clears enables and every stored attribute
  task automatic t_reset();
    set_cfg(4'h3);
    @(posedge ref_clk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    #1;
    check({msr_ack_out, msr_fault_out, top_mem_high_enable_out, var_dram_enable_out,
      fixed_attr_modify_enable_out, fixed_dram_attr_enable_out}, 6'h00);
    check({mmio_out, read_to_dram_out, write_to_dram_out}, 3'b011);
    set_cfg(4'h2);
    attr(1'b0, 7'h03, 2'h0, 2'h0);
    attr(1'b0, 7'h57, 2'h0, 2'h0);
    $display("reset test done");
  endtask : t_reset

  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    #1;
    check({msr_ack_out, msr_fault_out, top_mem_high_enable_out, var_dram_enable_out,
      fixed_attr_modify_enable_out, fixed_dram_attr_enable_out}, 6'h00);
    t_register();
    t_attributes();
    t_classify();
    t_reset();
    print_verdict();
  end
endmodule : system_configuration_reg_bench
